// [ucrt_pkg.sv]
package ucrt_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_RX_HOLD     = 5'h00;
  localparam logic [4:0] OFS_INT_EN      = 5'h01;
  localparam logic [4:0] OFS_INT_STAT    = 5'h02;
  localparam logic [4:0] OFS_LINE_CTL    = 5'h03;
  localparam logic [4:0] OFS_MODEM_CTL   = 5'h04;
  localparam logic [4:0] OFS_LINE_STAT   = 5'h05;
  localparam logic [4:0] OFS_MODEM_STAT  = 5'h06;
  localparam logic [4:0] OFS_SCRATCH     = 5'h07;
  localparam logic [4:0] OFS_DIV_LOW     = 5'h08;
  localparam logic [4:0] OFS_DIV_HIGH    = 5'h09;
  localparam logic [4:0] OFS_FEAT_CTL    = 5'h0A;
  localparam logic [4:0] OFS_ENH_FEAT    = 5'h0B;
  localparam logic [4:0] OFS_TX_CNT      = 5'h0C;
  localparam logic [4:0] OFS_TX_TRG      = 5'h0D;
  localparam logic [4:0] OFS_RX_CNT      = 5'h0E;
  localparam logic [4:0] OFS_RX_TRG      = 5'h0F;
  localparam logic [4:0] OFS_SPEC_CHAR   = 5'h10;
  localparam logic [4:0] OFS_RESUME_ONE  = 5'h11;
  localparam logic [4:0] OFS_RESUME_TWO  = 5'h12;
  localparam logic [4:0] OFS_PAUSE_ONE   = 5'h13;
  localparam logic [4:0] OFS_PAUSE_TWO   = 5'h14;
  localparam logic [4:0] OFS_FIFO_CTL    = 5'h15;
  localparam logic [4:0] OFS_EVT_STAT    = 5'h16;
  localparam logic [4:0] OFS_EVT_MASK    = 5'h17;
  // ----------------------------------------------------------------
  // Reset values and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_ZERO        = 8'h00;
  localparam logic [7:0] RST_INT_STAT    = 8'h01;
  localparam logic [7:0] RST_LINE_STAT   = 8'h60;
  localparam logic [7:0] RST_SCRATCH     = 8'hFF;
  localparam logic [7:0] ISR_RX_TRIGGER  = 8'h04;
  localparam logic [7:0] FIFO_MAX        = 8'h40;
  localparam int         IER_RX_BIT      = 0;
  localparam int         MCR_DTR_BIT     = 0;
  localparam int         MCR_RTS_BIT     = 1;
  localparam int         MCR_IR_BIT      = 6;
  localparam int         LCR_BREAK_BIT   = 6;
  localparam int         EVT_RX_TRG_BIT  = 0;
  localparam int         EVT_RX_OVF_BIT  = 1;
  localparam int         EVT_BITS        = 2;
endpackage : ucrt_pkg

// [ucrt_rx_level.sv]
`timescale 1ns/100ps
// Receive FIFO occupancy count and trigger compare
module ucrt_rx_level #(
  parameter int DEPTH = 64
) (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       push,
  input  wire logic       pop,
  input  wire logic       flush,
  input  wire logic [7:0] trigger,
  output logic      [7:0] level,
  output logic            at_trigger,
  output logic            overflow
);
  initial begin
    if (DEPTH < 1 || DEPTH > 255) $error("ucrt_rx_level: DEPTH out of range");
  end

  localparam logic [7:0] DEPTH_B = 8'(DEPTH);
  logic do_push;
  logic do_pop;
  assign do_push = push && (level != DEPTH_B);
  assign do_pop  = pop && (level != ucrt_pkg::RST_ZERO);
  assign overflow = push && !pop && (level == DEPTH_B);

  // ----------------------------------------------------------------
  // Level counter
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst || flush) begin
      level <= ucrt_pkg::RST_ZERO;
    end else if (do_push && !do_pop) begin
      level <= level + 8'h01;
    end else if (do_pop && !do_push) begin
      level <= level - 8'h01;
    end
  end

  // Level comparison; trigger zero means always at level
  assign at_trigger = (level >= trigger);
endmodule : ucrt_rx_level

// [ucrt_channel.sv]
`timescale 1ns/100ps
// One UART channel: reset defaults, registers and receive trigger
module ucrt_channel #(
  parameter int FIFO_DEPTH = 64
) (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic [4:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       rx_push,
  input  wire logic [7:0] rx_byte,
  input  wire logic       tx_push,
  input  wire logic       tx_pop,
  input  wire logic [3:0] modem_in,
  output logic            serial_out,
  output logic            infrared_out,
  output logic            rts_n,
  output logic            dtr_n,
  output logic            irq
);
  initial begin
    if (FIFO_DEPTH != 64) $error("ucrt_channel: FIFO_DEPTH must be 64");
  end

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  localparam int EVT_W = ucrt_pkg::EVT_BITS;
  logic [7:0] interrupt_enable_reg;
  logic [7:0] fifo_control_reg;
  logic [7:0] line_control_reg;
  logic [7:0] modem_control_reg;
  logic [7:0] scratchpad_reg;
  logic [7:0] feature_control_reg;
  logic [7:0] enhanced_feature_reg;
  logic [7:0] tx_fifo_trigger_reg;
  logic [7:0] rx_trigger_setting_reg;
  logic [7:0] special_char_status_reg;
  logic [7:0] resume_char_one_reg;
  logic [7:0] resume_char_two_reg;
  logic [7:0] pause_char_one_reg;
  logic [7:0] pause_char_two_reg;
  logic [7:0] baud_divisor_low_reg;
  logic [7:0] baud_divisor_high_reg;
  logic [7:0] receive_holding_reg;
  logic [7:0] tx_fifo_level_count_reg;
  logic [3:0] modem_sync1_reg;
  logic [3:0] modem_sync2_reg;
  logic [3:0] modem_prev_reg;
  logic [3:0] modem_delta_reg;
  logic [3:0] modem_delta_next;
  logic [EVT_W-1:0] evt_stat_reg;
  logic [EVT_W-1:0] evt_mask_reg;
  logic [EVT_W-1:0] evt_set;
  logic [7:0] interrupt_status_next;
  logic [7:0] line_status_next;
  logic [7:0] rd_next;
  logic [7:0] rx_fifo_level_count;
  logic       rx_at_trigger;
  logic       rx_overflow;
  logic       rx_pop;
  logic       rx_flush;
  logic       rx_trg_irq;

  // Address decode helper, shared by write and read paths
  function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // ----------------------------------------------------------------
  // Receive level tracking
  // ----------------------------------------------------------------
  assign rx_pop   = reg_rd && hit(reg_addr, ucrt_pkg::OFS_RX_HOLD);
  assign rx_flush = reg_wr && hit(reg_addr, ucrt_pkg::OFS_FIFO_CTL) && reg_wdata[1];

  ucrt_rx_level #(
    .DEPTH (FIFO_DEPTH)
  ) u_rx_level (
    .core_clk   (core_clk),
    .sys_rst    (sys_rst),
    .push       (rx_push),
    .pop        (rx_pop),
    .flush      (rx_flush),
    .trigger    (rx_trigger_setting_reg),
    .level      (rx_fifo_level_count),
    .at_trigger (rx_at_trigger),
    .overflow   (rx_overflow)
  );

  // Trigger interrupt only with data present; clears when level drops
  assign rx_trg_irq = interrupt_enable_reg[ucrt_pkg::IER_RX_BIT] && rx_at_trigger
                      && (rx_fifo_level_count != ucrt_pkg::RST_ZERO);

  // ----------------------------------------------------------------
  // Software-written registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      interrupt_enable_reg    <= ucrt_pkg::RST_ZERO;
      fifo_control_reg        <= ucrt_pkg::RST_ZERO;
      line_control_reg        <= ucrt_pkg::RST_ZERO;
      modem_control_reg       <= ucrt_pkg::RST_ZERO;
      feature_control_reg     <= ucrt_pkg::RST_ZERO;
      enhanced_feature_reg    <= ucrt_pkg::RST_ZERO;
      tx_fifo_trigger_reg     <= ucrt_pkg::RST_ZERO;
      rx_trigger_setting_reg  <= ucrt_pkg::RST_ZERO;
      resume_char_one_reg     <= ucrt_pkg::RST_ZERO;
      resume_char_two_reg     <= ucrt_pkg::RST_ZERO;
      pause_char_one_reg      <= ucrt_pkg::RST_ZERO;
      pause_char_two_reg      <= ucrt_pkg::RST_ZERO;
      scratchpad_reg          <= ucrt_pkg::RST_SCRATCH;
      evt_mask_reg            <= '0;
    end else if (reg_wr) begin
      case (reg_addr)
        ucrt_pkg::OFS_INT_EN:     interrupt_enable_reg <= reg_wdata;
        ucrt_pkg::OFS_FIFO_CTL:   fifo_control_reg     <= reg_wdata;
        ucrt_pkg::OFS_LINE_CTL:   line_control_reg     <= reg_wdata;
        ucrt_pkg::OFS_MODEM_CTL:  modem_control_reg    <= reg_wdata;
        ucrt_pkg::OFS_SCRATCH:    scratchpad_reg       <= reg_wdata;
        ucrt_pkg::OFS_FEAT_CTL:   feature_control_reg  <= reg_wdata;
        ucrt_pkg::OFS_ENH_FEAT:   enhanced_feature_reg <= reg_wdata;
        ucrt_pkg::OFS_TX_TRG: begin
          // Values above full depth would never fire; saturate them
          tx_fifo_trigger_reg <= (reg_wdata > ucrt_pkg::FIFO_MAX) ?
                                 ucrt_pkg::FIFO_MAX : reg_wdata;
        end
        ucrt_pkg::OFS_RX_TRG: begin
          rx_trigger_setting_reg <= (reg_wdata > ucrt_pkg::FIFO_MAX) ?
                                    ucrt_pkg::FIFO_MAX : reg_wdata;
        end
        ucrt_pkg::OFS_RESUME_ONE: resume_char_one_reg  <= reg_wdata;
        ucrt_pkg::OFS_RESUME_TWO: resume_char_two_reg  <= reg_wdata;
        ucrt_pkg::OFS_PAUSE_ONE:  pause_char_one_reg   <= reg_wdata;
        ucrt_pkg::OFS_PAUSE_TWO:  pause_char_two_reg   <= reg_wdata;
        ucrt_pkg::OFS_EVT_MASK:   evt_mask_reg         <= reg_wdata[EVT_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // Divisors and holding data keep no reset, saving reset fan-out
  always_ff @(posedge core_clk) begin
    if (reg_wr && hit(reg_addr, ucrt_pkg::OFS_DIV_LOW)) begin
      baud_divisor_low_reg <= reg_wdata;
    end
    if (reg_wr && hit(reg_addr, ucrt_pkg::OFS_DIV_HIGH)) begin
      baud_divisor_high_reg <= reg_wdata;
    end
    if (rx_push) begin
      receive_holding_reg <= rx_byte;
    end
  end

  // ----------------------------------------------------------------
  // Hardware status: transmit level, special character, modem
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst || (reg_wr && hit(reg_addr, ucrt_pkg::OFS_FIFO_CTL) && reg_wdata[2])) begin
      tx_fifo_level_count_reg <= ucrt_pkg::RST_ZERO;
    end else if (tx_push && !tx_pop && tx_fifo_level_count_reg != ucrt_pkg::FIFO_MAX) begin
      tx_fifo_level_count_reg <= tx_fifo_level_count_reg + 8'h01;
    end else if (tx_pop && !tx_push && tx_fifo_level_count_reg != ucrt_pkg::RST_ZERO) begin
      tx_fifo_level_count_reg <= tx_fifo_level_count_reg - 8'h01;
    end
  end

  // Special character match against second pause character
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      special_char_status_reg <= ucrt_pkg::RST_ZERO;
    end else if (rx_push && enhanced_feature_reg[5] && rx_byte == pause_char_two_reg) begin
      special_char_status_reg <= rx_byte;
    end
  end

  // Two-stage sync for the modem pins; only stage two is read
  always_ff @(posedge core_clk) begin
    modem_sync1_reg <= modem_in;
    modem_sync2_reg <= modem_sync1_reg;
  end

  // Change bits: a new change wins over the read that clears
  always_comb begin
    modem_delta_next = modem_delta_reg;
    if (reg_rd && hit(reg_addr, ucrt_pkg::OFS_MODEM_STAT)) begin
      modem_delta_next = 4'h0;
    end
    modem_delta_next = modem_delta_next | (modem_sync2_reg ^ modem_prev_reg);
  end

  always_ff @(posedge core_clk) begin
    modem_prev_reg <= modem_sync2_reg;
    if (sys_rst) begin
      modem_delta_reg <= 4'h0;
    end else begin
      modem_delta_reg <= modem_delta_next;
    end
  end

  // ----------------------------------------------------------------
  // Event status, write one to clear, set wins
  // ----------------------------------------------------------------
  always_comb begin
    evt_set = '0;
    evt_set[ucrt_pkg::EVT_RX_TRG_BIT] = rx_trg_irq;
    evt_set[ucrt_pkg::EVT_RX_OVF_BIT] = rx_overflow;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      evt_stat_reg <= '0;
    end else if (reg_wr && hit(reg_addr, ucrt_pkg::OFS_EVT_STAT)) begin
      evt_stat_reg <= (evt_stat_reg & ~reg_wdata[EVT_W-1:0]) | evt_set;
    end else begin
      evt_stat_reg <= evt_stat_reg | evt_set;
    end
  end

  // ----------------------------------------------------------------
  // Derived status views
  // ----------------------------------------------------------------
  always_comb begin
    interrupt_status_next = rx_trg_irq ? ucrt_pkg::ISR_RX_TRIGGER
                                       : ucrt_pkg::RST_INT_STAT;
    line_status_next = ucrt_pkg::RST_LINE_STAT;
    if (tx_fifo_level_count_reg != ucrt_pkg::RST_ZERO) begin
      line_status_next[6:5] = 2'b00;
    end
    line_status_next[0] = (rx_fifo_level_count != ucrt_pkg::RST_ZERO);
    line_status_next[1] = evt_stat_reg[ucrt_pkg::EVT_RX_OVF_BIT];
  end

  // ----------------------------------------------------------------
  // Read path, data one cycle after the strobe
  // ----------------------------------------------------------------
  always_comb begin
    rd_next = ucrt_pkg::RST_ZERO;
    case (reg_addr)
      ucrt_pkg::OFS_RX_HOLD:    rd_next = receive_holding_reg;
      ucrt_pkg::OFS_INT_EN:     rd_next = interrupt_enable_reg;
      ucrt_pkg::OFS_INT_STAT:   rd_next = interrupt_status_next;
      ucrt_pkg::OFS_LINE_CTL:   rd_next = line_control_reg;
      ucrt_pkg::OFS_MODEM_CTL:  rd_next = modem_control_reg;
      ucrt_pkg::OFS_LINE_STAT:  rd_next = line_status_next;
      ucrt_pkg::OFS_MODEM_STAT: rd_next = {modem_sync2_reg, modem_delta_reg};
      ucrt_pkg::OFS_SCRATCH:    rd_next = scratchpad_reg;
      ucrt_pkg::OFS_DIV_LOW:    rd_next = baud_divisor_low_reg;
      ucrt_pkg::OFS_DIV_HIGH:   rd_next = baud_divisor_high_reg;
      ucrt_pkg::OFS_FEAT_CTL:   rd_next = feature_control_reg;
      ucrt_pkg::OFS_ENH_FEAT:   rd_next = enhanced_feature_reg;
      ucrt_pkg::OFS_TX_CNT:     rd_next = tx_fifo_level_count_reg;
      ucrt_pkg::OFS_RX_CNT:     rd_next = rx_fifo_level_count;
      ucrt_pkg::OFS_SPEC_CHAR:  rd_next = special_char_status_reg;
      ucrt_pkg::OFS_RESUME_ONE: rd_next = resume_char_one_reg;
      ucrt_pkg::OFS_RESUME_TWO: rd_next = resume_char_two_reg;
      ucrt_pkg::OFS_PAUSE_ONE:  rd_next = pause_char_one_reg;
      ucrt_pkg::OFS_PAUSE_TWO:  rd_next = pause_char_two_reg;
      ucrt_pkg::OFS_EVT_STAT:   rd_next[EVT_W-1:0] = evt_stat_reg;
      ucrt_pkg::OFS_EVT_MASK:   rd_next[EVT_W-1:0] = evt_mask_reg;
      default:                  rd_next = ucrt_pkg::RST_ZERO;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reg_rdata <= ucrt_pkg::RST_ZERO;
    end else if (reg_rd) begin
      reg_rdata <= rd_next;
    end else begin
      reg_rdata <= ucrt_pkg::RST_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers, all from flops
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      serial_out   <= 1'b1;
      infrared_out <= 1'b0;
      rts_n        <= 1'b1;
      dtr_n        <= 1'b1;
      irq          <= 1'b0;
    end else begin
      // No serialiser here: line idles, break forces low
      serial_out   <= !line_control_reg[ucrt_pkg::LCR_BREAK_BIT];
      infrared_out <= 1'b0;
      rts_n        <= !modem_control_reg[ucrt_pkg::MCR_RTS_BIT];
      dtr_n        <= !modem_control_reg[ucrt_pkg::MCR_DTR_BIT];
      irq          <= |(evt_stat_reg & evt_mask_reg);
    end
  end
endmodule : ucrt_channel

// [ucrt_channel_checker.sv]
`timescale 1ns/100ps
// ------------------------------------------------------------
// Port checks: reset defaults and receive trigger
// ------------------------------------------------------------
module ucrt_channel_checker #(
  parameter int FIFO_DEPTH = 64
) (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic [4:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       rx_push,
  input  wire logic       tx_push,
  input  wire logic       serial_out,
  input  wire logic       infrared_out,
  input  wire logic       rts_n,
  input  wire logic       dtr_n
);
  logic fresh_reg;

  default clocking @(posedge core_clk); endclocking

  // Untouched since reset; only then must a read show the reset value
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      fresh_reg <= 1'h1;
    end else if (reg_wr || rx_push || tx_push) begin
      fresh_reg <= 1'h0;
    end
  end

  a_tx_idle_mark: assert property (sys_rst |=> serial_out)
    else $error("serial output not high after reset");
  a_ir_low: assert property (sys_rst |=> !infrared_out)
    else $error("infrared output not low after reset");
  a_rts_off: assert property ($fell(sys_rst) |-> rts_n)
    else $error("request-to-send active at reset release");
  a_dtr_off: assert property (sys_rst [*2] |-> dtr_n)
    else $error("terminal-ready active during reset");
  a_trig_write_only: assert property (disable iff (sys_rst)
    reg_rd && reg_addr == ucrt_pkg::OFS_RX_TRG |=> reg_rdata == 8'h00)
    else $error("receive trigger readable");
  a_isr_reset_val: assert property (disable iff (sys_rst)
    fresh_reg && reg_rd && reg_addr == ucrt_pkg::OFS_INT_STAT |=> reg_rdata == 8'h01)
    else $error("interrupt status reset value wrong");
  a_lsr_reset_val: assert property (disable iff (sys_rst)
    fresh_reg && reg_rd && reg_addr == ucrt_pkg::OFS_LINE_STAT |=> reg_rdata == 8'h60)
    else $error("line status reset value wrong");
  a_spr_reset_val: assert property (disable iff (sys_rst)
    fresh_reg && reg_rd && reg_addr == ucrt_pkg::OFS_SCRATCH |=> reg_rdata == 8'hFF)
    else $error("scratchpad reset value wrong");
  a_msr_delta_clear: assert property (disable iff (sys_rst)
    fresh_reg && reg_rd && reg_addr == ucrt_pkg::OFS_MODEM_STAT |=> reg_rdata[3:0] == 4'h0)
    else $error("modem change bits set after reset");
  a_rx_count_max: assert property (disable iff (sys_rst)
    reg_rd && reg_addr == ucrt_pkg::OFS_RX_CNT |=> reg_rdata <= 8'(FIFO_DEPTH))
    else $error("receive level above fifo depth");
endmodule : ucrt_channel_checker

bind ucrt_channel ucrt_channel_checker #(.FIFO_DEPTH(FIFO_DEPTH)) ucrt_channel_checker_inst (
  .core_clk, .sys_rst, .reg_addr, .reg_wr, .reg_rd, .reg_rdata, .rx_push, .tx_push,
  .serial_out, .infrared_out, .rts_n, .dtr_n);

// [ucrt_line_partner.sv]
`timescale 1ns/100ps
// ------------------------------------------------------------
// Line side: bytes arriving from the transceiver
// ------------------------------------------------------------
module ucrt_line_partner (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       go,
  input  wire logic [6:0] len,
  input  wire logic       slow,
  output logic            rx_push,
  output logic      [7:0] rx_byte,
  output logic            busy
);
  logic [6:0] left_reg;
  logic       gap_reg;

  assign busy = (left_reg != 7'h00);

  // One byte a cycle, or every other cycle when slow
  always_ff @(posedge core_clk) begin
    rx_push <= 1'h0;
    gap_reg <= slow & ~gap_reg;
    rx_byte <= ~rx_byte; // Idle lanes keep moving so stale data never looks valid
    if (sys_rst) begin
      left_reg <= 7'h00;
      gap_reg  <= 1'h0;
      rx_byte  <= 8'hA5;
    end else if (go) begin
      left_reg <= len;
    end else if (busy && !gap_reg) begin
      rx_push  <= 1'h1;
      rx_byte  <= {1'h0, left_reg};
      left_reg <= left_reg - 7'h01;
    end
  end
endmodule : ucrt_line_partner

// [ucrt_channel_tb_top.sv]
`timescale 1ns/100ps
module ucrt_channel_tb_top;
  logic       core_clk;
  logic       sys_rst;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       rx_push;
  logic [7:0] rx_byte;
  logic       tx_push;
  logic       tx_pop;
  logic [3:0] modem_in;
  logic       serial_out;
  logic       infrared_out;
  logic       rts_n;
  logic       dtr_n;
  logic       irq;
  logic       go;
  logic [6:0] len;
  logic       slow;
  logic       busy;
  logic [7:0] rd_val;
  int         n_mismatch;
  int         n_compared;
  int         cycles;

  ucrt_channel #(.FIFO_DEPTH(64)) ucrt_channel_inst (.core_clk, .sys_rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rx_push, .rx_byte, .tx_push, .tx_pop,
    .modem_in, .serial_out, .infrared_out, .rts_n, .dtr_n, .irq);
  ucrt_line_partner ucrt_line_partner_inst (.core_clk, .sys_rst, .go, .len, .slow,
    .rx_push, .rx_byte, .busy);

  // ------------------------------------------------------------
  // Clock, time-zero values and hang guard
  // ------------------------------------------------------------
  initial begin
    core_clk = 1'h0; sys_rst = 1'h1; reg_addr = 5'h00; reg_wdata = 8'h00;
    reg_wr = 1'h0; reg_rd = 1'h0; tx_push = 1'h0; tx_pop = 1'h0;
    modem_in = 4'hA; go = 1'h0; len = 7'h00; slow = 1'h0;
    n_mismatch = 0; n_compared = 0; cycles = 0;
  end
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  // ------------------------------------------------------------
  // Bus, line and compare helpers
  // ------------------------------------------------------------
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk8
  task automatic chk1(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask : chk1
  // Extra edge after the strobe so back-to-back calls never double-drive it
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'h1;
    @(posedge core_clk); reg_wr <= 1'h0;
    @(posedge core_clk);
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    reg_addr <= a; reg_rd <= 1'h1;
    @(posedge core_clk); reg_rd <= 1'h0;
    #1 d = reg_rdata; // Taken while the data stands, off the edge
    @(posedge core_clk);
  endtask : rd
  task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp, input string what);
    logic [7:0] v;
    rd(a, v);
    chk8(what, exp, v);
  endtask : rd_chk
  task automatic ticks(input int n);
    repeat (n) @(posedge core_clk);
  endtask : ticks
  task automatic burst(input logic [6:0] n, input logic s);
    go <= 1'h1; len <= n; slow <= s;
    @(posedge core_clk); go <= 1'h0;
    @(posedge core_clk);
    for (int k = 0; k < 300 && busy; k++) @(posedge core_clk);
  endtask : burst
  task automatic tx_pulse(input logic pop);
    tx_push <= !pop; tx_pop <= pop;
    @(posedge core_clk); tx_push <= 1'h0; tx_pop <= 1'h0;
    @(posedge core_clk);
  endtask : tx_pulse
  task automatic apply_reset;
    sys_rst <= 1'h1;
    ticks(2);
    sys_rst <= 1'h0;
  endtask : apply_reset

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic test_reset_defaults;
    logic [7:0] exp;
    wr(ucrt_pkg::OFS_SCRATCH, 8'h00); wr(ucrt_pkg::OFS_LINE_CTL, 8'h40);
    wr(ucrt_pkg::OFS_MODEM_CTL, 8'h03); wr(ucrt_pkg::OFS_INT_EN, 8'h01);
    wr(ucrt_pkg::OFS_RX_TRG, 8'h02); wr(ucrt_pkg::OFS_RESUME_ONE, 8'h55);
    wr(ucrt_pkg::OFS_DIV_LOW, 8'h3C);
    burst(7'h03, 1'h0); tx_pulse(1'h0);
    chk1("serial_out before", 1'h0, serial_out);
    apply_reset();
    chk1("serial_out", 1'h1, serial_out);
    chk1("infrared_out", 1'h0, infrared_out);
    chk1("rts_n", 1'h1, rts_n);
    chk1("dtr_n", 1'h1, dtr_n);
    rd(ucrt_pkg::OFS_MODEM_STAT, rd_val);
    chk8("modem change bits", 8'h00, {4'h0, rd_val[3:0]});
    rd_chk(ucrt_pkg::OFS_DIV_LOW, 8'h3C, "divisor kept");
    for (int a = 1; a < 24; a++) begin
      exp = (a == ucrt_pkg::OFS_INT_STAT) ? 8'h01 : (a == ucrt_pkg::OFS_LINE_STAT) ? 8'h60 :
            (a == ucrt_pkg::OFS_SCRATCH) ? 8'hFF : 8'h00;
      if (a != ucrt_pkg::OFS_MODEM_STAT && a != ucrt_pkg::OFS_DIV_LOW &&
          a != ucrt_pkg::OFS_DIV_HIGH) begin
        rd_chk(5'(a), exp, $sformatf("register %0h", a));
      end
    end
    rd(ucrt_pkg::OFS_MODEM_STAT, rd_val);
    chk8("modem levels", 8'hA0, {rd_val[7:4], 4'h0});
    $display("test reset_defaults done");
  endtask : test_reset_defaults

  task automatic test_tx_count;
    tx_pulse(1'h0); tx_pulse(1'h0);
    rd_chk(ucrt_pkg::OFS_TX_CNT, 8'h02, "tx level");
    rd_chk(ucrt_pkg::OFS_LINE_STAT, 8'h00, "line status busy");
    tx_pulse(1'h1); tx_pulse(1'h1);
    rd_chk(ucrt_pkg::OFS_TX_CNT, 8'h00, "tx level drained");
    rd_chk(ucrt_pkg::OFS_LINE_STAT, 8'h60, "line status idle");
    $display("test tx_count done");
  endtask : test_tx_count

  task automatic test_rx_trigger;
    wr(ucrt_pkg::OFS_INT_EN, 8'h01); wr(ucrt_pkg::OFS_EVT_MASK, 8'h01);
    wr(ucrt_pkg::OFS_RX_TRG, 8'h03);
    burst(7'h02, 1'h1);
    rd_chk(ucrt_pkg::OFS_INT_STAT, 8'h01, "status below trigger");
    chk1("irq below trigger", 1'h0, irq);
    burst(7'h01, 1'h0);
    rd_chk(ucrt_pkg::OFS_INT_STAT, 8'h04, "status at trigger");
    rd_chk(ucrt_pkg::OFS_RX_CNT, 8'h03, "rx level");
    ticks(3);
    chk1("irq at trigger", 1'h1, irq);
    rd(ucrt_pkg::OFS_RX_HOLD, rd_val);
    rd_chk(ucrt_pkg::OFS_INT_STAT, 8'h01, "status after pop");
    wr(ucrt_pkg::OFS_EVT_STAT, 8'h01); ticks(2);
    chk1("irq cleared", 1'h0, irq);
    wr(ucrt_pkg::OFS_INT_EN, 8'h00); burst(7'h01, 1'h0);
    rd_chk(ucrt_pkg::OFS_INT_STAT, 8'h01, "status disabled");
    rd_chk(ucrt_pkg::OFS_RX_TRG, 8'h00, "trigger readback");
    wr(ucrt_pkg::OFS_FIFO_CTL, 8'h02);
    rd_chk(ucrt_pkg::OFS_RX_CNT, 8'h00, "rx level flushed");
    $display("test rx_trigger done");
  endtask : test_rx_trigger

  task automatic test_trigger_bounds;
    wr(ucrt_pkg::OFS_INT_EN, 8'h01); wr(ucrt_pkg::OFS_RX_TRG, 8'h50);
    burst(7'h3F, 1'h0);
    rd_chk(ucrt_pkg::OFS_INT_STAT, 8'h01, "status at 63");
    burst(7'h01, 1'h0);
    rd_chk(ucrt_pkg::OFS_INT_STAT, 8'h04, "status at 64");
    burst(7'h01, 1'h0);
    rd_chk(ucrt_pkg::OFS_RX_CNT, 8'h40, "rx level full");
    ticks(2);
    chk1("irq full", 1'h1, irq);
    wr(ucrt_pkg::OFS_EVT_MASK, 8'h00); ticks(2);
    chk1("irq masked", 1'h0, irq);
    wr(ucrt_pkg::OFS_FIFO_CTL, 8'h02);
    rd_chk(ucrt_pkg::OFS_INT_STAT, 8'h01, "status flushed");
    $display("test trigger_bounds done");
  endtask : test_trigger_bounds

  task automatic give_verdict;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  // Main sequence
  initial begin
    @(posedge core_clk);
    apply_reset();
    test_reset_defaults();
    test_tx_count();
    test_rx_trigger();
    test_trigger_bounds();
    give_verdict();
  end
endmodule : ucrt_channel_tb_top
